/* mipt_axil_slave.sv */
`timescale 1ns/10ps
`include "mipt_params.svh"

module mipt_axil_slave
   import mipt_pkg::*;
#(
   parameter int ADDR_W = 10
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output mipt_wr_t wr,
   input wire logic wr_ok,
   output logic [7:0] rd_idx,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);

   localparam int LSB = 2;

   logic aw_q, aw_d, w_q, w_d, ar_q, ar_d;
   logic awr_q, awr_d, wr_q, wr_d, arr_q, arr_d;
   logic bv_q, bv_d, rv_q, rv_d;
   logic [7:0] awi_q, awi_d, ari_q, ari_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [3:0] ws_q, ws_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;
   logic do_wr, do_rd;

   // ========================================================================
   // Address and data are held until both are present, in either order.
   always_comb begin
      do_wr = aw_q && w_q && !bv_q;
      do_rd = ar_q && !rv_q;
      aw_d = (aw_q || (awvalid && awr_q)) && !do_wr;
      w_d = (w_q || (wvalid && wr_q)) && !do_wr;
      ar_d = (ar_q || (arvalid && arr_q)) && !do_rd;
      awi_d = (awvalid && awr_q) ? awaddr[LSB +: 8] : awi_q;
      ari_d = (arvalid && arr_q) ? araddr[LSB +: 8] : ari_q;
      wd_d = (wvalid && wr_q) ? wdata : wd_q;
      ws_d = (wvalid && wr_q) ? wstrb : ws_q;
      bv_d = do_wr || (bv_q && !bready);
      rv_d = do_rd || (rv_q && !rready);
      br_d = do_wr ? (wr_ok ? `MIPT_RESP_OKAY : `MIPT_RESP_SLVERR) : br_q;
      rr_d = do_rd ? (rd_ok ? `MIPT_RESP_OKAY : `MIPT_RESP_SLVERR) : rr_q;
      rd_d = do_rd ? rd_data : rd_q;
      awr_d = !aw_d && !bv_d;
      wr_d = !w_d && !bv_d;
      arr_d = !ar_d && !rv_d;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         ar_q <= 1'b0;
         awr_q <= 1'b1;
         wr_q <= 1'b1;
         arr_q <= 1'b1;
         bv_q <= 1'b0;
         rv_q <= 1'b0;
         awi_q <= '0;
         ari_q <= '0;
         wd_q <= '0;
         ws_q <= '0;
         rd_q <= '0;
         br_q <= `MIPT_RESP_OKAY;
         rr_q <= `MIPT_RESP_OKAY;
      end else begin
         aw_q <= aw_d;
         w_q <= w_d;
         ar_q <= ar_d;
         awr_q <= awr_d;
         wr_q <= wr_d;
         arr_q <= arr_d;
         bv_q <= bv_d;
         rv_q <= rv_d;
         awi_q <= awi_d;
         ari_q <= ari_d;
         wd_q <= wd_d;
         ws_q <= ws_d;
         rd_q <= rd_d;
         br_q <= br_d;
         rr_q <= rr_d;
      end
   end

   assign awready = awr_q;
   assign wready = wr_q;
   assign arready = arr_q;
   assign bvalid = bv_q;
   assign bresp = br_q;
   assign rvalid = rv_q;
   assign rresp = rr_q;
   assign rdata = rd_q;
   assign rd_idx = ari_q;
   assign wr = '{en: do_wr, idx: awi_q, data: wd_q, strb: ws_q};

endmodule : mipt_axil_slave

/* mipt_params.svh */
`ifndef MIPT_PARAMS_SVH
`define MIPT_PARAMS_SVH

// ==========================================================================
// Clock and line timing.
`define MIPT_CLK_NS 20
`define MIPT_UNIT_BITS 8
`define MIPT_QUANTUM_BITS 512
`define MIPT_RXG2_ADD 5
`define MIPT_TXG_ADD 4
`define MIPT_MBPS_10 10
`define MIPT_MBPS_100 100
`define MIPT_MBPS_1000 1000

// ==========================================================================
// Register indices; the byte address is four times the index.
`define MIPT_IDX_FC_LEN 8'h07
`define MIPT_IDX_RXG1 8'h0A
`define MIPT_IDX_RXG2 8'h0B
`define MIPT_IDX_TXG 8'h0C
`define MIPT_IDX_PTHR 8'h0E
`define MIPT_IDX_CTRL 8'h20
`define MIPT_IDX_STAT 8'h21

// ==========================================================================
// Reset values.
`define MIPT_RST_FC_LEN 16'h005E
`define MIPT_RST_RXG1 8'h08
`define MIPT_RST_RXG2 8'h07
`define MIPT_RST_TXG 10'h008
`define MIPT_RST_PTHR 16'h002F
`define MIPT_RST_CTRL 3'h4

// ==========================================================================
// Bus responses.
`define MIPT_RESP_OKAY 2'h0
`define MIPT_RESP_SLVERR 2'h2

`endif

/* mipt_phy.sv */
`timescale 1ns/10ps
// ==========================================================================
// Carrier source of the far side; it idles low between bursts.
module mipt_phy (
   input wire logic core_clk,
   input wire logic go,
   input wire logic [7:0] hold,
   output logic crs
);
   logic [7:0] left_q;
   initial left_q = 8'h00;
   assign crs = (left_q != 8'h00);
   always @(posedge core_clk) begin
      if (go) begin
         left_q <= hold;
      end else if (left_q != 8'h00) begin
         left_q <= left_q - 8'h01;
      end
   end
endmodule : mipt_phy

/* mipt_pkg.sv */
package mipt_pkg;

   // =======================================================================
   // Line rate, control and status layouts.
   typedef enum logic [1:0] {
      spd_10,
      spd_100,
      spd_1000,
      spd_1000_alt
   } mipt_speed_t;

   typedef struct packed {
      mipt_speed_t speed;
      logic hdx;
   } mipt_ctrl_t;

   typedef struct packed {
      logic pause_run;
      logic tx_busy;
      logic txgap_met;
      logic gap2_done;
      logic gap1_done;
      logic carrier;
   } mipt_stat_t;

   typedef struct packed {
      logic en;
      logic [7:0] idx;
      logic [31:0] data;
      logic [3:0] strb;
   } mipt_wr_t;

endpackage : mipt_pkg

/* mipt_rate_tick.sv */
`timescale 1ns/10ps
`include "mipt_params.svh"

module mipt_rate_tick
   import mipt_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input mipt_speed_t speed,
   output logic [1:0] unit_inc
);

   // =======================================================================
   // Tenths of a bit time per clock; one unit is eight bit times.
   localparam int ACC_W = 9;
   localparam int TENTHS_PER_UNIT = `MIPT_UNIT_BITS * 10;

   logic [ACC_W-1:0] acc_q, acc_d;
   logic [1:0] inc_q, inc_d;

   function automatic logic [ACC_W-1:0] step(input mipt_speed_t s);
      unique case (s)
         spd_10: step = ACC_W'(`MIPT_MBPS_10 * `MIPT_CLK_NS / 100);
         spd_100: step = ACC_W'(`MIPT_MBPS_100 * `MIPT_CLK_NS / 100);
         spd_1000, spd_1000_alt: begin
            step = ACC_W'(`MIPT_MBPS_1000 * `MIPT_CLK_NS / 100);
         end
      endcase
   endfunction : step

   // At gigabit rate more than one unit passes per clock, so the count
   // carries a fraction instead of dividing the clock.
   always_comb begin
      logic [ACC_W-1:0] sum;
      sum = acc_q + step(speed);
      inc_d = 2'h0;
      for (int i = 0; i < 3; i++) begin
         if (sum >= ACC_W'(TENTHS_PER_UNIT)) begin
            sum = sum - ACC_W'(TENTHS_PER_UNIT);
            inc_d = inc_d + 2'h1;
         end
      end
      acc_d = sum;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         acc_q <= '0;
         inc_q <= 2'h0;
      end else begin
         acc_q <= acc_d;
         inc_q <= inc_d;
      end
   end

   assign unit_inc = inc_q;

   property p_slow_rate;
      @(posedge core_clk) disable iff (!nrst)
      (speed != spd_1000 && speed != spd_1000_alt) |=> (unit_inc < 2'h2);
   endproperty
   a_slow_rate: assert property (p_slow_rate)
      else $error("More than one unit per clock below gigabit rate.");

endmodule : mipt_rate_tick

/* mipt_timing.sv */
`timescale 1ns/10ps
`include "mipt_params.svh"

module mipt_timing
   import mipt_pkg::*;
#(
   parameter int ADDR_W = 10,
   parameter int CNT_W = 22
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic crs,
   input wire logic tx_pending,
   input wire logic tx_frame_end,
   input wire logic pause_sent,
   input wire logic fc_extend,
   output logic tx_start,
   output logic pause_due,
   output logic [15:0] pause_len
);

   localparam int Q_UNITS = `MIPT_QUANTUM_BITS / `MIPT_UNIT_BITS;

   typedef enum logic [2:0] {
      df_carrier,
      df_gap1,
      df_gap2,
      df_ready
   } mipt_defer_t;

   // =======================================================================
   // Helpers.
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            merge[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
   endfunction : merge

   function automatic logic idx_hit(input logic [7:0] idx);
      idx_hit = (idx == `MIPT_IDX_FC_LEN) || (idx == `MIPT_IDX_RXG1) ||
                (idx == `MIPT_IDX_RXG2) || (idx == `MIPT_IDX_TXG) ||
                (idx == `MIPT_IDX_PTHR) || (idx == `MIPT_IDX_CTRL) ||
                (idx == `MIPT_IDX_STAT);
   endfunction : idx_hit

   function automatic logic [CNT_W-1:0] sat_add(input logic [CNT_W-1:0] c,
                                                input logic [1:0] i);
      logic [CNT_W:0] s;
      s = {1'b0, c} + {{(CNT_W-1){1'b0}}, i};
      sat_add = s[CNT_W] ? '1 : s[CNT_W-1:0];
   endfunction : sat_add

   // =======================================================================
   // Register bus.
   mipt_wr_t wr;
   logic wr_ok, rd_ok;
   logic [7:0] rd_idx;
   logic [31:0] rd_data;

   mipt_axil_slave #(
      .ADDR_W(ADDR_W)
   ) u_bus (
      .core_clk(core_clk),
      .nrst(nrst),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .wr(wr),
      .wr_ok(wr_ok),
      .rd_idx(rd_idx),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   // =======================================================================
   // Configuration registers.
   logic [15:0] fclen_q, fclen_d, pthr_q, pthr_d;
   logic [7:0] rxg1_q, rxg1_d, rxg2_q, rxg2_d;
   logic [9:0] txg_q, txg_d;
   mipt_ctrl_t ctrl_q, ctrl_d;
   mipt_stat_t stat;

   always_comb begin
      logic [31:0] m;
      m = '0;
      fclen_d = fclen_q;
      rxg1_d = rxg1_q;
      rxg2_d = rxg2_q;
      txg_d = txg_q;
      pthr_d = pthr_q;
      ctrl_d = ctrl_q;
      if (wr.en) begin
         case (wr.idx)
            `MIPT_IDX_FC_LEN: begin
               m = merge(32'(fclen_q), wr.data, wr.strb);
               fclen_d = m[15:0];
            end
            `MIPT_IDX_RXG1: begin
               m = merge(32'(rxg1_q), wr.data, wr.strb);
               rxg1_d = m[7:0];
            end
            `MIPT_IDX_RXG2: begin
               m = merge(32'(rxg2_q), wr.data, wr.strb);
               rxg2_d = m[7:0];
            end
            `MIPT_IDX_TXG: begin
               m = merge(32'(txg_q), wr.data, wr.strb);
               txg_d = m[9:0];
            end
            `MIPT_IDX_PTHR: begin
               m = merge(32'(pthr_q), wr.data, wr.strb);
               pthr_d = m[15:0];
            end
            `MIPT_IDX_CTRL: begin
               m = merge(32'(ctrl_q), wr.data, wr.strb);
               ctrl_d = mipt_ctrl_t'(m[$bits(mipt_ctrl_t)-1:0]);
            end
            default: m = '0;
         endcase
      end
   end

   always_comb begin
      wr_ok = idx_hit(wr.idx);
      rd_ok = idx_hit(rd_idx);
      case (rd_idx)
         `MIPT_IDX_FC_LEN: rd_data = 32'(fclen_q);
         `MIPT_IDX_RXG1: rd_data = 32'(rxg1_q);
         `MIPT_IDX_RXG2: rd_data = 32'(rxg2_q);
         `MIPT_IDX_TXG: rd_data = 32'(txg_q);
         `MIPT_IDX_PTHR: rd_data = 32'(pthr_q);
         `MIPT_IDX_CTRL: rd_data = 32'(ctrl_q);
         `MIPT_IDX_STAT: rd_data = 32'(stat);
         default: rd_data = '0;
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fclen_q <= `MIPT_RST_FC_LEN;
         rxg1_q <= `MIPT_RST_RXG1;
         rxg2_q <= `MIPT_RST_RXG2;
         txg_q <= `MIPT_RST_TXG;
         pthr_q <= `MIPT_RST_PTHR;
         ctrl_q <= mipt_ctrl_t'(`MIPT_RST_CTRL);
      end else begin
         fclen_q <= fclen_d;
         rxg1_q <= rxg1_d;
         rxg2_q <= rxg2_d;
         txg_q <= txg_d;
         pthr_q <= pthr_d;
         ctrl_q <= ctrl_d;
      end
   end

   // =======================================================================
   // Line-rate units: one unit is eight bit times at the current speed.
   logic [1:0] unit_inc;

   mipt_rate_tick u_rate (
      .core_clk(core_clk),
      .nrst(nrst),
      .speed(ctrl_q.speed),
      .unit_inc(unit_inc)
   );

   // =======================================================================
   // Deferral, transmit gap and pause refresh.
   logic crs_m_q, crs_s_q;
   mipt_defer_t st_q, st_d;
   logic [CNT_W-1:0] rx_cnt_q, rx_cnt_d, tx_cnt_q, tx_cnt_d;
   logic [CNT_W-1:0] pcnt_q, pcnt_d;
   logic busy_q, busy_d, prun_q, prun_d;
   logic start_q, start_d, due_q, due_d;
   logic [CNT_W-1:0] gap1_u, gap2_u, txgap_u, pthr_u;
   logic gap1_hit, gap2_hit, txgap_met, go;

   // A shared count serves both receive gaps, so they always start together.
   always_comb begin
      gap1_u = CNT_W'(rxg1_q);
      gap2_u = CNT_W'(rxg2_q) + CNT_W'(`MIPT_RXG2_ADD);
      txgap_u = CNT_W'(txg_q) + CNT_W'(`MIPT_TXG_ADD);
      pthr_u = CNT_W'(pthr_q) * CNT_W'(Q_UNITS);
      gap1_hit = rx_cnt_q >= gap1_u;
      gap2_hit = rx_cnt_q >= gap2_u;
      txgap_met = tx_cnt_q >= txgap_u;
      go = tx_pending && !busy_q && txgap_met &&
           (!ctrl_q.hdx || st_q == df_ready);
      st_d = st_q;
      rx_cnt_d = sat_add(rx_cnt_q, unit_inc);
      if (!ctrl_q.hdx) begin
         st_d = df_carrier;
         rx_cnt_d = '0;
      end else begin
         unique case (st_q)
            df_carrier: begin
               rx_cnt_d = '0;
               if (!crs_s_q) begin
                  st_d = df_gap1;
               end
            end
            df_gap1: begin
               if (crs_s_q && !gap1_hit) begin
                  st_d = df_carrier;
                  rx_cnt_d = '0;
               end else if (gap1_hit) begin
                  st_d = df_gap2;
               end
            end
            df_gap2: begin
               if (gap2_hit) begin
                  st_d = df_ready;
               end
            end
            df_ready: begin
               if (go || (crs_s_q && !tx_pending)) begin
                  st_d = df_carrier;
                  rx_cnt_d = '0;
               end
            end
         endcase
      end
      busy_d = go || (busy_q && !tx_frame_end);
      tx_cnt_d = tx_frame_end ? '0 :
                 (busy_q ? tx_cnt_q : sat_add(tx_cnt_q, unit_inc));
      start_d = go;
      due_d = prun_q && pcnt_q >= pthr_u && fc_extend;
      prun_d = pause_sent || (prun_q && pcnt_q < pthr_u);
      pcnt_d = pause_sent ? '0 : sat_add(pcnt_q, unit_inc);
      stat = '{pause_run: prun_q, tx_busy: busy_q, txgap_met: txgap_met,
               gap2_done: st_q == df_ready, gap1_done: gap1_hit,
               carrier: crs_s_q};
   end

   // The carrier pin is asynchronous; only the second stage is used.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         crs_m_q <= 1'b0;
         crs_s_q <= 1'b0;
         st_q <= df_carrier;
         rx_cnt_q <= '0;
         tx_cnt_q <= '1;
         pcnt_q <= '0;
         busy_q <= 1'b0;
         prun_q <= 1'b0;
         start_q <= 1'b0;
         due_q <= 1'b0;
      end else begin
         crs_m_q <= crs;
         crs_s_q <= crs_m_q;
         st_q <= st_d;
         rx_cnt_q <= rx_cnt_d;
         tx_cnt_q <= tx_cnt_d;
         pcnt_q <= pcnt_d;
         busy_q <= busy_d;
         prun_q <= prun_d;
         start_q <= start_d;
         due_q <= due_d;
      end
   end

   assign tx_start = start_q;
   assign pause_due = due_q;
   assign pause_len = fclen_q;

   // =======================================================================
   // Checks.
   property p_fdx_idle;
      @(posedge core_clk) disable iff (!nrst)
      !ctrl_q.hdx |=> (st_q == df_carrier && rx_cnt_q == '0);
   endproperty
   a_fdx_idle: assert property (p_fdx_idle)
      else $error("Receive gap timers ran in full duplex.");

   property p_gap_restart;
      @(posedge core_clk) disable iff (!nrst)
      (ctrl_q.hdx && st_q == df_gap1 && crs_s_q && !gap1_hit)
         |=> (st_q == df_carrier && !tx_start);
   endproperty
   a_gap_restart: assert property (p_gap_restart)
      else $error("Carrier in the first gap did not restart deferral.");

   property p_gap1_len;
      @(posedge core_clk) disable iff (!nrst)
      (ctrl_q.hdx && st_q == df_gap1 && !crs_s_q &&
       rx_cnt_q >= CNT_W'(rxg1_q)) |=> (st_q == df_gap2);
   endproperty
   a_gap1_len: assert property (p_gap1_len)
      else $error("First receive gap did not expire on time.");

   property p_gap2_len;
      @(posedge core_clk) disable iff (!nrst)
      (ctrl_q.hdx && st_q == df_gap2 &&
       rx_cnt_q >= CNT_W'(rxg2_q) + CNT_W'(`MIPT_RXG2_ADD))
         |=> (st_q == df_ready);
   endproperty
   a_gap2_len: assert property (p_gap2_len)
      else $error("Second receive gap did not expire on time.");

   property p_hdx_defer;
      @(posedge core_clk) disable iff (!nrst)
      (ctrl_q.hdx && st_q != df_ready) |=> !tx_start;
   endproperty
   a_hdx_defer: assert property (p_hdx_defer)
      else $error("Transmit started before both receive gaps expired.");

   property p_txgap;
      @(posedge core_clk) disable iff (!nrst)
      tx_start |-> ($past(tx_cnt_q) >= CNT_W'($past(txg_q)) +
                    CNT_W'(`MIPT_TXG_ADD));
   endproperty
   a_txgap: assert property (p_txgap)
      else $error("Back-to-back frame sent before the transmit gap.");

   property p_pause_start;
      @(posedge core_clk) disable iff (!nrst)
      (pause_sent && pthr_q != 16'h0000)
         |=> (prun_q && pcnt_q == '0) ##1 !pause_due;
   endproperty
   a_pause_start: assert property (p_pause_start)
      else $error("Pause refresh timer did not restart.");

   property p_pause_due;
      @(posedge core_clk) disable iff (!nrst)
      pause_due |-> ($past(fc_extend) && $past(prun_q) &&
                     $past(pcnt_q) >= CNT_W'($past(pthr_q)) *
                     CNT_W'(Q_UNITS));
   endproperty
   a_pause_due: assert property (p_pause_due)
      else $error("Pause refresh came before the threshold.");

endmodule : mipt_timing

/* tb.sv */
`timescale 1ns/10ps
module tb;
   logic core_clk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, tx_pending = 0, tx_frame_end = 0;
   logic pause_sent = 0, fc_extend = 0, go = 0, crs;
   logic [9:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, d;
   logic [3:0] wstrb = 0;
   logic [7:0] hold = 0;
   logic [1:0] bresp, rresp, r;
   logic awready, wready, bvalid, arready, rvalid, tx_start, pause_due;
   logic [15:0] pause_len;
   int fails = 0, compares = 0, ns = 0, np = 0, n, s0, e;
   logic [9:0] ra[8] = '{10'h01C, 10'h028, 10'h02C, 10'h030, 10'h038,
      10'h080, 10'h084, 10'h03C};
   logic [31:0] rd[8] = '{32'h5E, 32'h8, 32'h7, 32'h8, 32'h2F, 32'h4,
      32'h8, 32'h0};
   logic [1:0] rr[8] = '{0, 0, 0, 0, 0, 0, 0, 2'h2};
   // Clocks per ten units at each rate, so gigabit fits an integer row.
   int cu[4] = '{2, 2, 0, 6}, uu[4] = '{40, 40, 400, 4};
   int tg[4] = '{0, 6, 1, 36};

   always #10 core_clk = ~core_clk;
   always @(negedge core_clk) begin
      if (tx_start === 1'b1) ns++;
      if (pause_due === 1'b1) np++;
   end

   mipt_phy u_phy (.core_clk(core_clk), .go(go), .hold(hold), .crs(crs));
   mipt_timing u_dut (.core_clk(core_clk), .nrst(nrst), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .crs(crs), .tx_pending(tx_pending),
      .tx_frame_end(tx_frame_end), .pause_sent(pause_sent),
      .fc_extend(fc_extend), .tx_start(tx_start), .pause_due(pause_due),
      .pause_len(pause_len));

   // =======================================================================
   // Reporting.
   task print_verdict;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   task chk(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
   endtask : chk
   task rng(input int g, input int lo, input int hi);
      chk(32'(g >= lo && g <= hi), 32'h1);
   endtask : rng

   // =======================================================================
   // Bus and stimulus helpers; ready is sampled mid-cycle to avoid races.
   task axw(input logic [9:0] a, input logic [31:0] v);
      bit ad, wd, ah, wh;
      @(posedge core_clk);
      awaddr <= a; wdata <= v; wstrb <= 4'hF;
      awvalid <= 1; wvalid <= 1; bready <= 1;
      ad = 0;
      wd = 0;
      // Each channel is released at its own handshake edge.
      while (!(ad && wd)) begin
         @(negedge core_clk);
         ah = !ad && awready === 1'b1;
         wh = !wd && wready === 1'b1;
         @(posedge core_clk);
         if (ah) begin
            awvalid <= 0;
            ad = 1;
         end
         if (wh) begin
            wvalid <= 0;
            wd = 1;
         end
      end
      do @(negedge core_clk); while (bvalid !== 1);
      r = bresp;
      @(posedge core_clk);
      bready <= 0;
   endtask : axw
   task axr(input logic [9:0] a);
      @(posedge core_clk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(negedge core_clk); while (arready !== 1);
      @(posedge core_clk);
      arvalid <= 0;
      do @(negedge core_clk); while (rvalid !== 1);
      d = rdata; r = rresp;
      @(posedge core_clk);
      rready <= 0;
   endtask : axr
   task wt(input bit s, output int c);
      c = 0;
      do begin
         @(negedge core_clk);
         c++;
      end while ((s ? pause_due : tx_start) !== 1'b1 && c < 3000);
      @(posedge core_clk);
   endtask : wt
   task pulse(input bit s);
      @(posedge core_clk);
      if (s) pause_sent <= 1; else tx_frame_end <= 1;
      @(posedge core_clk);
      pause_sent <= 0; tx_frame_end <= 0;
   endtask : pulse
   task carrier(input int len);
      @(posedge core_clk);
      go <= 1; hold <= len[7:0];
      @(posedge core_clk);
      go <= 0;
      repeat (len) @(posedge core_clk);
   endtask : carrier
   task done(input string s);
      $display("test %s finished", s);
   endtask : done

   // A hang would otherwise hide behind the unbounded bus waits forever.
   initial begin
      #600000;
      fails++;
      print_verdict();
   end

   // =======================================================================
   // Main sequence.
   initial begin
      repeat (4) @(posedge core_clk);
      nrst <= 1;
      @(negedge core_clk);
      chk({awready, wready, arready, bvalid, rvalid}, 32'h1C);
      chk({tx_start, pause_due}, 32'h0);
      chk(pause_len, 32'h5E);
      for (int i = 0; i < 8; i++) begin
         axr(ra[i]);
         chk(d, rd[i]);
         chk(r, rr[i]);
      end
      done("regs");
      axw(10'h030, 32'hFFFFFFFF);
      chk(r, 32'h0);
      axr(10'h030);
      chk(d, 32'h3FF);
      axw(10'h03C, 32'h1);
      chk(r, 32'h2);
      axw(10'h01C, 32'h1234);
      repeat (2) @(negedge core_clk);
      chk(pause_len, 32'h1234);
      done("fields");
      @(posedge core_clk);
      tx_pending <= 1;
      wt(0, n);
      for (int i = 0; i < 4; i++) begin
         axw(10'h080, cu[i]);
         axw(10'h030, tg[i]);
         pulse(0);
         wt(0, n);
         e = uu[i] * (tg[i] + 4) / 10;
         rng(n, e - uu[i] / 10, e + uu[i] / 10 + 6);
      end
      tx_pending <= 0;
      pulse(0);
      done("txgap");
      axw(10'h080, 32'h3);
      axw(10'h028, 32'h4);
      axw(10'h02C, 32'h3);
      axw(10'h030, 32'h0);
      repeat (60) @(posedge core_clk);
      carrier(10);
      tx_pending <= 1;
      wt(0, n);
      rng(n, 28, 44);
      tx_pending <= 0;
      pulse(0);
      s0 = ns;
      carrier(10);
      tx_pending <= 1;
      repeat (3) @(posedge core_clk);
      carrier(20);
      chk(ns, s0);
      wt(0, n);
      rng(n, 28, 44);
      tx_pending <= 0;
      pulse(0);
      s0 = ns;
      carrier(10);
      tx_pending <= 1;
      repeat (20) @(posedge core_clk);
      carrier(30);
      chk(ns, s0 + 1);
      tx_pending <= 0;
      pulse(0);
      done("defer");
      axw(10'h038, 32'h1);
      fc_extend <= 1;
      pulse(1);
      wt(1, n);
      rng(n, 248, 268);
      fc_extend <= 0;
      s0 = np;
      pulse(1);
      repeat (300) @(posedge core_clk);
      chk(np, s0);
      done("pause");
      // A reset in mid-run must bring back the documented defaults.
      nrst <= 0;
      repeat (2) @(posedge core_clk);
      nrst <= 1;
      @(negedge core_clk);
      chk({awready, wready, arready, bvalid, rvalid}, 32'h1C);
      chk(pause_len, 32'h5E);
      axr(10'h030);
      chk(d, 32'h8);
      done("reset");
      print_verdict();
   end
endmodule : tb
